//--- hw/smd_pkg.sv
package smd_pkg;

   // Descriptor window, byte offsets within the parameter table
   localparam logic [7:0]  SMD_DESC0_OFS    = 8'h48;
   localparam logic [7:0]  SMD_DESC1_OFS    = 8'h50;
   localparam logic [7:0]  SMD_DESC_END     = 8'h58;
   localparam logic [7:0]  SMD_FILL_BYTE    = 8'hFF;

   // Descriptor fields
   localparam logic [7:0]  SMD_READ_MASK    = 8'h08;
   localparam logic [1:0]  SMD_ADDR_LEN_VAR = 2'h3;
   localparam logic [1:0]  SMD_RSVD_HI      = 2'h3;
   localparam logic [3:0]  SMD_LAT_VAR      = 4'hF;
   localparam logic [7:0]  SMD_DETECT_CMD   = 8'h65;
   localparam logic [5:0]  SMD_RSVD_LO      = 6'h3F;
   localparam logic        SMD_CMD_DESC     = 1'h0;
   localparam logic        SMD_DESC_LAST0   = 1'h0;
   localparam logic        SMD_DESC_LAST1   = 1'h0;
   localparam logic [31:0] SMD_CFG_REG_ADDR = 32'h0000_0004;
   localparam int          SMD_ARCH_BIT     = 3;

   // Map indices
   localparam logic [1:0]  SMD_IDX_BOTTOM   = 2'h1;
   localparam logic [1:0]  SMD_IDX_TOP      = 2'h2;
   localparam logic [1:0]  SMD_IDX_UNIFORM  = 2'h3;

   typedef enum logic [1:0] {
      SMD_MAP_INVALID = 2'h0,
      SMD_MAP_BOTTOM  = 2'h1,
      SMD_MAP_TOP     = 2'h3,
      SMD_MAP_UNIFORM = 2'h2
   } smd_map_e;

   typedef struct packed {
      logic     valid;
      smd_map_e map;
      logic     low_has_param;
      logic     high_has_param;
   } smd_map_s;

endpackage : smd_pkg

//--- hw/smd_sector_map_detect.sv
`timescale 1ns/1ps
`default_nettype none
module smd_sector_map_detect
   import smd_pkg::*;
(
   input  wire logic       clk,          // 20 MHz clock
   input  wire logic       nrst,         // Async reset, active low
   input  wire logic       rd_en,        // Parameter byte read strobe
   input  wire logic [7:0] rd_addr,      // Parameter byte offset
   output logic      [7:0] rd_data,      // Byte returned, one cycle later
   output logic            rd_valid,     // rd_data is valid
   input  wire logic [7:0] low_cfg3,     // Low die config register three
   input  wire logic [7:0] high_cfg3,    // High die config register three
   output logic      [1:0] map_index,    // Concatenated architecture bits
   output var smd_map_s    map_sel       // Decoded active map
);

   logic       rst_m_q;
   logic       rst_n_q;
   logic [7:0] data_d;
   logic [7:0] data_q;
   logic       valid_q;
   logic [1:0] idx_d;
   logic [1:0] idx_q;
   smd_map_s   map_d;
   smd_map_s   map_q;

   // Descriptor words; the low die one has its final-descriptor bit 0
   // so the host keeps walking to the high die entry.
   localparam logic [31:0] DESC_CMD = {
      SMD_READ_MASK,
      SMD_ADDR_LEN_VAR,
      SMD_RSVD_HI,
      SMD_LAT_VAR,
      SMD_DETECT_CMD,
      SMD_RSVD_LO,
      SMD_CMD_DESC,
      SMD_DESC_LAST0
   };
   localparam logic [31:0] DESC_CMD1 = {DESC_CMD[31:1], SMD_DESC_LAST1};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   // Table lookup is pure decode of constants, so a read has no side effects
   always_comb begin
      logic [7:0]  rel;
      logic [63:0] blk;
      rel = 8'h00;
      blk = 64'h0;
      data_d = SMD_FILL_BYTE;
      if (rd_addr >= SMD_DESC0_OFS && rd_addr < SMD_DESC1_OFS) begin
         rel = rd_addr - SMD_DESC0_OFS;
         blk = {SMD_CFG_REG_ADDR, DESC_CMD};
         data_d = blk[{rel[2:0], 3'h0} +: 8];
      end else if (rd_addr >= SMD_DESC1_OFS && rd_addr < SMD_DESC_END) begin
         rel = rd_addr - SMD_DESC1_OFS;
         blk = {SMD_CFG_REG_ADDR, DESC_CMD1};
         data_d = blk[{rel[2:0], 3'h0} +: 8];
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         data_q  <= 8'h00;
         valid_q <= 1'b0;
      end else begin
         valid_q <= rd_en;
         if (rd_en) begin
            data_q <= data_d;
         end
      end
   end

   // Architecture bit: 0 hybrid, 1 uniform; low die is the MSB
   always_comb begin
      idx_d = {low_cfg3[SMD_ARCH_BIT], high_cfg3[SMD_ARCH_BIT]};
      map_d = '0;
      unique case (idx_d)
         SMD_IDX_BOTTOM: begin
            map_d = '{1'b1, SMD_MAP_BOTTOM, 1'b1, 1'b0};
         end
         SMD_IDX_TOP: begin
            map_d = '{1'b1, SMD_MAP_TOP, 1'b0, 1'b1};
         end
         SMD_IDX_UNIFORM: begin
            map_d = '{1'b1, SMD_MAP_UNIFORM, 1'b0, 1'b0};
         end
         default: begin
            // Both hybrid is unsupported, flagged rather than guessed
            map_d = '{1'b0, SMD_MAP_INVALID, 1'b0, 1'b0};
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         idx_q <= 2'h0;
         map_q <= '0;
      end else begin
         idx_q <= idx_d;
         map_q <= map_d;
      end
   end

   assign rd_data   = data_q;
   assign rd_valid  = valid_q;
   assign map_index = idx_q;
   assign map_sel   = map_q;

   AST_RD_LAT: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en |=> rd_valid && rd_data == $past(data_d))
      else $error("read data not returned next cycle");

   AST_MASK: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && rd_addr == 8'h4B |=> rd_data == 8'h08)
      else $error("read mask byte wrong");

   AST_CMD: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && (rd_addr == 8'h49 || rd_addr == 8'h51) |=> rd_data == 8'h65)
      else $error("detect instruction byte wrong");

   AST_LAT_LEN: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && rd_addr == 8'h4A |=> rd_data == 8'hFF)
      else $error("length latency byte wrong");

   AST_LOW_BYTE: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && rd_addr == 8'h48 |=> rd_data == 8'hFC)
      else $error("descriptor low byte wrong");

   AST_ADDR: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && rd_addr == 8'h4C |=> rd_data == 8'h04)
      else $error("detect address byte wrong");

   AST_SECOND: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && rd_addr == 8'h54 |=> rd_data == 8'h04)
      else $error("second descriptor address wrong");

   AST_MAP: assert property (@(posedge clk) disable iff (!rst_n_q)
      ##1 map_sel.valid |-> map_sel.low_has_param + map_sel.high_has_param
         <= 1 && map_index == {$past(low_cfg3[3]), $past(high_cfg3[3])})
      else $error("map index or parameter region wrong");

   AST_DECODE: assert property (@(posedge clk) disable iff (!rst_n_q)
      low_cfg3[3] && !high_cfg3[3] |=> map_sel.map == SMD_MAP_TOP)
      else $error("top map not selected");

   // The map checks below also gate on rst_n_q, so the edge at which the synchroniser
   // lets go is never judged against flops that still hold reset values.
   // A configuration seen there is only loaded one edge later.
   AST_BOTTOM: assert property (@(posedge clk) disable iff (!rst_n_q)
      rst_n_q && !low_cfg3[3] && high_cfg3[3]
      |=> map_sel.map == SMD_MAP_BOTTOM && map_sel.low_has_param)
      else $error("bottom map not selected");

   AST_UNIFORM: assert property (@(posedge clk) disable iff (!rst_n_q)
      rst_n_q && low_cfg3[3] && high_cfg3[3]
      |=> map_sel.map == SMD_MAP_UNIFORM && !map_sel.low_has_param
         && !map_sel.high_has_param)
      else $error("uniform map not selected");

   AST_INVALID: assert property (@(posedge clk) disable iff (!rst_n_q)
      rst_n_q && !low_cfg3[3] && !high_cfg3[3]
      |=> !map_sel.valid && map_sel.map == SMD_MAP_INVALID)
      else $error("unsupported index not flagged");

   AST_ARCH: assert property (@(posedge clk) disable iff (!rst_n_q)
      rst_n_q |=> map_index[1] == $past(low_cfg3[SMD_ARCH_BIT])
         && map_index[0] == $past(high_cfg3[SMD_ARCH_BIT]))
      else $error("architecture bits not carried to index");

   AST_FILL: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && (rd_addr < SMD_DESC0_OFS || rd_addr >= SMD_DESC_END)
      |=> rd_data == SMD_FILL_BYTE)
      else $error("byte outside descriptors not filled");

   AST_LEN: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && (rd_addr == 8'h4A || rd_addr == 8'h52)
      |=> rd_data[7:6] == SMD_ADDR_LEN_VAR)
      else $error("address length field wrong");

   AST_LAT: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && (rd_addr == 8'h4A || rd_addr == 8'h52)
      |=> rd_data[3:0] == SMD_LAT_VAR)
      else $error("latency field wrong");

   AST_RSVD_HI: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && (rd_addr == 8'h4A || rd_addr == 8'h52)
      |=> rd_data[5:4] == SMD_RSVD_HI)
      else $error("upper reserved field wrong");

   AST_RSVD_LO: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && (rd_addr == 8'h48 || rd_addr == 8'h50)
      |=> rd_data[7:2] == SMD_RSVD_LO && rd_data[1] == SMD_CMD_DESC)
      else $error("lower reserved or descriptor kind wrong");

   AST_MASK_HI: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && rd_addr == 8'h53 |=> rd_data == SMD_READ_MASK)
      else $error("second descriptor mask wrong");

   AST_ADDR_ZERO: assert property (@(posedge clk) disable iff (!rst_n_q)
      rd_en && rd_addr inside {8'h4D, 8'h4E, 8'h4F, 8'h55, 8'h56, 8'h57}
      |=> rd_data == 8'h00)
      else $error("detect address upper bytes wrong");

   AST_VALID_ONE: assert property (@(posedge clk) disable iff (!rst_n_q)
      !rd_en |=> !rd_valid)
      else $error("read valid without a request");

   AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n_q)
      rst_n_q && !rd_en |=> $stable(rd_data))
      else $error("read data changed without a request");

endmodule : smd_sector_map_detect
`default_nettype wire

//--- testbench/smd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smd_host_model (
   input  wire logic       clk,      // Clock
   output logic            rd_en,    // Read strobe
   output logic      [7:0] rd_addr,  // Byte offset
   input  wire logic [7:0] rd_data,  // Returned byte
   input  wire logic       rd_valid  // Return strobe
);
   initial begin
      rd_en   = 1'b0;
      rd_addr = 8'h00;
   end
   // Sample last answer first, so back-to-back requests need no gap
   task automatic xfer(input logic [7:0] a, input logic en,
                       output logic [7:0] d, output logic v);
      @(negedge clk);
      d       = rd_data;
      v       = rd_valid;
      rd_en   = en;
      rd_addr = a;
   endtask : xfer
   // Index 00h is probed here but never programmed in real use
   function automatic logic [1:0] form_index(input logic [7:0] lo, hi);
      return {lo[3], hi[3]};
   endfunction : form_index
endmodule : smd_host_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import smd_pkg::*;
   logic       clk = 1'b0;
   logic       nrst = 1'b0;
   logic       rd_en, rd_valid, v;
   logic [7:0] rd_addr, rd_data, d;
   logic [7:0] low_cfg3 = 8'h00;
   logic [7:0] high_cfg3 = 8'h00;
   logic [1:0] map_index;
   smd_map_s   map_sel;
   logic [1:0] exp_idx;
   int         fails = 0;
   int         num_checks = 0;
   int         cycles = 0;
   // Offset beside expected byte
   logic [15:0] rd_rows [20] = '{
      16'h48FC, 16'h4965,
      16'h4AFF, 16'h4B08,
      16'h4C04, 16'h4D00, 16'h4E00, 16'h4F00,
      16'h50FC, 16'h5165, 16'h52FF, 16'h5308,
      16'h5404, 16'h5500, 16'h5600, 16'h5700,
      16'h47FF, 16'h58FF, 16'h00FF, 16'hFFFF
   };
   // Low cfg, high cfg, then valid, map code, low param, high param
   logic [20:0] mp_rows [6] = '{
      {16'h0808, 5'h18},
      {16'hF708, 5'h16},
      {16'h08F7, 5'h1D},
      {16'hF7F7, 5'h00},
      {16'hFF00, 5'h1D},
      {16'h00FF, 5'h16}
   };

   smd_sector_map_detect smd_sector_map_detect_i (.clk(clk), .nrst(nrst),
      .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid), .low_cfg3(low_cfg3), .high_cfg3(high_cfg3),
      .map_index(map_index), .map_sel(map_sel));
   smd_host_model smd_host_model_i (.clk(clk), .rd_en(rd_en),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

   always #25 clk = ~clk;

   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk

   task automatic print_verdict;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   // Outputs must sit at zero through reset; map_sel and rd_valid also at the first edge after it
   task automatic do_reset;
      nrst = 1'b0;
      repeat (8) @(negedge clk);
      chk(map_sel === '0 && map_index === 2'h0 && rd_valid === 1'b0
          && rd_data === 8'h00, "held in reset");
      nrst = 1'b1;
      @(negedge clk);
      chk(map_sel === '0 && rd_valid === 1'b0, "leaving reset");
   endtask : do_reset

   always @(posedge clk) begin
      cycles++;
      if (cycles == 500) begin
         fails++;
         print_verdict();
      end
   end

   initial begin
      do_reset();
      for (int i = 0; i <= 20; i++) begin
         smd_host_model_i.xfer(rd_rows[i % 20][15:8], i < 20, d, v);
         if (i > 0)
            chk(v === 1'b1 && d === rd_rows[i-1][7:0], "byte");
      end
      smd_host_model_i.xfer(8'h48, 1'b0, d, v);
      chk(v === 1'b0 && d === 8'hFF, "valid one cycle");
      for (int i = 0; i < 6; i++) begin
         {low_cfg3, high_cfg3} = mp_rows[i][20:5];
         @(negedge clk);
         exp_idx = smd_host_model_i.form_index(low_cfg3, high_cfg3);
         chk(map_index === exp_idx, "index");
         chk(map_sel[4:2] === mp_rows[i][4:2], "map");
         chk(map_sel[1:0] === mp_rows[i][1:0], "param");
      end
      do_reset();
      smd_host_model_i.xfer(8'h49, 1'b1, d, v);
      smd_host_model_i.xfer(8'h49, 1'b0, d, v);
      chk(v === 1'b1 && d === 8'h65, "read after reset");
      chk(map_index === 2'h1, "map after reset");
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
